// >>> src/tcw_consts.svh
// Offsets, field positions and reset values of the terminal configuration block.
// Assumes APB byte addressing, one 32-bit word for each register index.
`ifndef TCW_CONSTS_SVH
`define TCW_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define TCW_IDX_CFG1 10'h001
`define TCW_IDX_CFG3 10'h003
`define TCW_IDX_STAT 10'h004
`define TCW_IDX_TRIG 10'h00D

// ----------------------------------------------------------------------
// Configuration word one fields
// ----------------------------------------------------------------------
`define TCW_B_OP_HI 15
`define TCW_B_OP_LO 14
`define TCW_B_MEM_AREA 13
`define TCW_B_MSG_MON 12
`define TCW_B_TRIG_EN 11
`define TCW_B_START_MATCH 10
`define TCW_B_STOP_MATCH 9
`define TCW_B_EXT_START 7
`define TCW_B_TFLAG_N 7
`define TCW_B_MON_ENABLED 2
`define TCW_B_MON_TRIGGERED 1
`define TCW_B_MIP 0

// Writable bits for each layout
`define TCW_WMASK_RT 16'hFF80
`define TCW_WMASK_RT_ALT 16'hFFFE
`define TCW_WMASK_MON 16'hFE80
`define TCW_WMASK_OTHER 16'hF000

// ----------------------------------------------------------------------
// Configuration word three fields
// ----------------------------------------------------------------------
`define TCW_B_ENHANCED 15
`define TCW_B_ALT_STATUS 5
`define TCW_WMASK_CFG3 16'h8020

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TCW_RST_CFG1 16'h8000
`define TCW_RST_CFG3 16'h0000
`define TCW_RST_TRIG 16'h0000

`endif

// >>> src/tcw_pkg.sv
// Types shared by the terminal configuration block.
// Assumes tcw_consts.svh is included by the modules that need numbers.
package tcw_pkg;

    // Which view of configuration word one is in force
    typedef enum logic [1:0] {
        TCW_LAY_RT,
        TCW_LAY_RT_ALT,
        TCW_LAY_MON,
        TCW_LAY_OTHER
    } tcw_layout_t;

    // Word monitor run state
    typedef enum logic {
        TCW_MON_IDLE,
        TCW_MON_RUN
    } tcw_mon_t;

endpackage

// >>> src/tcw_trigger.sv
// Word monitor start and stop on trigger match or external start edge.
// Assumes all inputs synchronous to clk_sys; arming is gated by the parent.
`timescale 1ns/100ps

module tcw_trigger (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic armed,
    input wire logic startOnMatch,
    input wire logic stopOnMatch,
    input wire logic extStartEnable,
    input wire logic externalStartPin,
    input wire logic wordValid,
    input wire logic [15:0] rxWord,
    input wire logic [15:0] trigWord,
    input wire logic clearTriggered,
    output logic monitorActive,
    output logic monitorTriggered
);

    tcw_pkg::tcw_mon_t monState;
    logic extPrev;
    logic extRise;
    logic match;
    logic startEvt;
    logic stopEvt;

    assign extRise = externalStartPin & ~extPrev;
    assign match = wordValid && (rxWord == trigWord);
    assign startEvt = armed && ((startOnMatch && match) || (extStartEnable && extRise));
    assign stopEvt = stopOnMatch && match;
    assign monitorActive = (monState == tcw_pkg::TCW_MON_RUN);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            extPrev <= 1'b0;
        end else begin
            extPrev <= externalStartPin;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            monState <= tcw_pkg::TCW_MON_IDLE;
        end else begin
            unique case (monState)
                tcw_pkg::TCW_MON_IDLE: begin
                    if (startEvt) begin
                        monState <= tcw_pkg::TCW_MON_RUN;
                    end
                end
                tcw_pkg::TCW_MON_RUN: begin
                    if (stopEvt) begin
                        monState <= tcw_pkg::TCW_MON_IDLE;
                    end
                end
            endcase
        end
    end

    // Sticky triggered flag, a new trigger beats the clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            monitorTriggered <= 1'b0;
        end else if (startEvt) begin
            monitorTriggered <= 1'b1;
        end else if (clearTriggered) begin
            monitorTriggered <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence matchStart;
        armed && startOnMatch && match && !monitorActive;
    endsequence

    chk_start_on_match: assert property (matchStart |=> monitorActive && monitorTriggered)
        else $error("monitor did not start on trigger match");
    chk_stop_on_match: assert property (monitorActive && stopEvt |=> !monitorActive)
        else $error("monitor did not stop on trigger match");
    chk_ext_rise_start: assert property (
        armed && extStartEnable && !monitorActive && externalStartPin && !$past(externalStartPin)
        |=> monitorActive)
        else $error("monitor did not start on external edge");
    chk_idle_unarmed: assert property (!armed && !monitorActive |=> !monitorActive)
        else $error("monitor started while not armed");

endmodule

// >>> src/tcw_config_one.sv
// Configuration word one of a redundant serial bus terminal, APB slave.
// Assumes one clock, the protocol engine supplies message busy and received words.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "tcw_consts.svh"

// Summary of operation
// - Enhanced RT: bit 7 low sets terminal flag
// - Enhanced RT: bit 0 reads message in progress
// - Alternate status needs enhanced mode enabled
// - Bits 15,14 select RT or monitor role
// - Bit 13 selects memory area A/B
// - Bit 12 enables message monitor
// - Alternate bits 11-9 set status 9-11
// - Alternate bits 8-6 set status 12-14
// - Alternate bit 5 sets broadcast received
// - Alternate bits 4,3 set busy, subsystem
// - Alternate bits 2,1 set bus control, flag
// - Monitor bits 12-0 need enhanced mode
// - Trigger enable required before monitor start
// - Start word monitor on trigger match
// - Stop word monitor on trigger match
// - External rising edge starts armed monitor
module tcw_config_one (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic msgBusy,
    input wire logic wordValid,
    input wire logic [15:0] rxWord,
    input wire logic externalStartPin,
    output logic rtModeSel,
    output logic monitorModeSel,
    output logic enhancedMode,
    output logic altStatusMode,
    output logic memoryAreaSelect,
    output logic messageMonitorEnable,
    output logic [10:0] rtStatusFlags,
    output logic wordMonitorActive,
    output logic monitorTriggered
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic tcw_pkg::tcw_layout_t layoutOf(input logic [15:0] c1,
                                                     input logic [15:0] c3);
        tcw_pkg::tcw_layout_t l;
        l = tcw_pkg::TCW_LAY_OTHER;
        if (c1[`TCW_B_OP_HI] && !c1[`TCW_B_OP_LO]) begin
            // Alternate view only usable with enhanced mode
            if (c3[`TCW_B_ALT_STATUS] && c3[`TCW_B_ENHANCED]) begin
                l = tcw_pkg::TCW_LAY_RT_ALT;
            end else begin
                l = tcw_pkg::TCW_LAY_RT;
            end
        end else if (!c1[`TCW_B_OP_HI] && c1[`TCW_B_OP_LO]) begin
            l = tcw_pkg::TCW_LAY_MON;
        end
        return l;
    endfunction

    function automatic logic [15:0] writeMask(input tcw_pkg::tcw_layout_t l);
        logic [15:0] m;
        m = `TCW_WMASK_OTHER;
        unique case (l)
            tcw_pkg::TCW_LAY_RT: m = `TCW_WMASK_RT;
            tcw_pkg::TCW_LAY_RT_ALT: m = `TCW_WMASK_RT_ALT;
            tcw_pkg::TCW_LAY_MON: m = `TCW_WMASK_MON;
            tcw_pkg::TCW_LAY_OTHER: m = `TCW_WMASK_OTHER;
        endcase
        return m;
    endfunction

    // Config bit 11-k drives status flag k (status word bits 9..19)
    function automatic logic [10:0] altFlags(input logic [15:0] c1);
        logic [10:0] f;
        f = 11'h000;
        for (int k = 0; k < 11; k++) begin
            f[k] = c1[11 - k];
        end
        return f;
    endfunction

    function automatic logic [15:0] laneMerge(input logic [15:0] cur,
                                              input logic [31:0] wd,
                                              input logic [3:0] strb,
                                              input logic [15:0] m);
        logic [15:0] bm;
        bm = {{8{strb[1]}}, {8{strb[0]}}} & m;
        return (cur & ~bm) | (wd[15:0] & bm);
    endfunction

    // ------------------------------------------------------------------
    // Storage and decode
    // ------------------------------------------------------------------
    logic [15:0] cfg1;
    logic [15:0] cfg3;
    logic [15:0] trigWord;
    logic msgInProgress;
    tcw_pkg::tcw_layout_t layout;
    logic [9:0] regIdx;
    logic hitCfg1;
    logic hitCfg3;
    logic hitTrig;
    logic hitStat;
    logic mapped;
    logic setupPhase;
    logic wrAccess;
    logic [15:0] cfg1View;
    logic [31:0] next_prdata;
    logic [10:0] next_flags;
    logic trigArmed;
    logic clearTrig;

    assign layout = layoutOf(cfg1, cfg3);
    assign regIdx = paddr[11:2];
    assign hitCfg1 = (regIdx == `TCW_IDX_CFG1);
    assign hitCfg3 = (regIdx == `TCW_IDX_CFG3);
    assign hitTrig = (regIdx == `TCW_IDX_TRIG);
    assign hitStat = (regIdx == `TCW_IDX_STAT);
    assign mapped = hitCfg1 | hitCfg3 | hitTrig | hitStat;
    assign setupPhase = psel && !penable;
    assign wrAccess = psel && penable && pwrite;

    // Zero wait state slave, error on unmapped address
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg1 <= `TCW_RST_CFG1;
        end else if (wrAccess && hitCfg1) begin
            cfg1 <= laneMerge(cfg1, pwdata, pstrb, writeMask(layout));
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg3 <= `TCW_RST_CFG3;
        end else if (wrAccess && hitCfg3) begin
            cfg3 <= laneMerge(cfg3, pwdata, pstrb, `TCW_WMASK_CFG3);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            trigWord <= `TCW_RST_TRIG;
        end else if (wrAccess && hitTrig) begin
            trigWord <= laneMerge(trigWord, pwdata, pstrb, 16'hFFFF);
        end
    end

    // Message in progress follows the engine's busy window
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            msgInProgress <= 1'b0;
        end else begin
            msgInProgress <= msgBusy;
        end
    end

    // ------------------------------------------------------------------
    // Mode outputs
    // ------------------------------------------------------------------
    assign rtModeSel = cfg1[`TCW_B_OP_HI] && !cfg1[`TCW_B_OP_LO];
    assign monitorModeSel = !cfg1[`TCW_B_OP_HI] && cfg1[`TCW_B_OP_LO];
    assign enhancedMode = cfg3[`TCW_B_ENHANCED];
    assign altStatusMode = (layout == tcw_pkg::TCW_LAY_RT_ALT);
    assign memoryAreaSelect = cfg1[`TCW_B_MEM_AREA];
    // In monitor role the enable only counts in enhanced mode
    assign messageMonitorEnable = cfg1[`TCW_B_MSG_MON]
                                  && (!monitorModeSel || enhancedMode);

    // ------------------------------------------------------------------
    // Status word flags
    // ------------------------------------------------------------------
    always_comb begin
        next_flags = 11'h000;
        unique case (layout)
            tcw_pkg::TCW_LAY_RT_ALT: next_flags = altFlags(cfg1);
            tcw_pkg::TCW_LAY_RT: next_flags[10] = enhancedMode && !cfg1[`TCW_B_TFLAG_N];
            tcw_pkg::TCW_LAY_MON: next_flags = 11'h000;
            tcw_pkg::TCW_LAY_OTHER: next_flags = 11'h000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rtStatusFlags <= 11'h000;
        end else begin
            rtStatusFlags <= next_flags;
        end
    end

    // ------------------------------------------------------------------
    // Word monitor trigger
    // ------------------------------------------------------------------
    assign trigArmed = monitorModeSel && enhancedMode && cfg1[`TCW_B_TRIG_EN];
    assign clearTrig = !cfg1[`TCW_B_TRIG_EN];

    tcw_trigger trigUnit (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .armed(trigArmed),
        .startOnMatch(cfg1[`TCW_B_START_MATCH]),
        .stopOnMatch(monitorModeSel && enhancedMode && cfg1[`TCW_B_STOP_MATCH]),
        .extStartEnable(cfg1[`TCW_B_EXT_START]),
        .externalStartPin(externalStartPin),
        .wordValid(wordValid),
        .rxWord(rxWord),
        .trigWord(trigWord),
        .clearTriggered(clearTrig),
        .monitorActive(wordMonitorActive),
        .monitorTriggered(monitorTriggered)
    );

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        cfg1View = cfg1 & writeMask(layout);
        unique case (layout)
            tcw_pkg::TCW_LAY_RT: cfg1View[`TCW_B_MIP] = msgInProgress && enhancedMode;
            tcw_pkg::TCW_LAY_RT_ALT: cfg1View[`TCW_B_MIP] = msgInProgress;
            tcw_pkg::TCW_LAY_MON: begin
                cfg1View[`TCW_B_MON_ENABLED] = enhancedMode;
                cfg1View[`TCW_B_MON_TRIGGERED] = monitorTriggered && enhancedMode;
                cfg1View[0] = wordMonitorActive && enhancedMode;
            end
            tcw_pkg::TCW_LAY_OTHER: cfg1View[0] = 1'b0;
        endcase
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hitCfg1) begin
            next_prdata[15:0] = cfg1View;
        end else if (hitCfg3) begin
            next_prdata[15:0] = cfg3;
        end else if (hitTrig) begin
            next_prdata[15:0] = trigWord;
        end else if (hitStat) begin
            next_prdata[13:0] = {monitorTriggered, wordMonitorActive, msgInProgress,
                                 rtStatusFlags};
        end
    end

    // Read data is captured in the setup phase, valid during access
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence cfg1WriteHigh;
        wrAccess && hitCfg1 && pstrb[1];
    endsequence

    sequence cfg1ReadSetup;
        setupPhase && !pwrite && hitCfg1;
    endsequence

    chk_tflag_active_low: assert property (
        layout == tcw_pkg::TCW_LAY_RT && enhancedMode
        |=> rtStatusFlags[10] == !$past(cfg1[`TCW_B_TFLAG_N]))
        else $error("terminal flag not active low");
    chk_rt_unused_zero: assert property (
        cfg1ReadSetup and layout == tcw_pkg::TCW_LAY_RT
        |=> prdata[6:1] == 6'h00 && prdata[31:16] == 16'h0000)
        else $error("unused bits read nonzero");
    chk_mip_readback: assert property (
        cfg1ReadSetup and layout == tcw_pkg::TCW_LAY_RT_ALT and msgInProgress
        |=> prdata[0])
        else $error("message in progress not shown");
    chk_alt_needs_enh: assert property (altStatusMode |-> enhancedMode)
        else $error("alternate view without enhanced mode");
    chk_role_select: assert property (
        cfg1WriteHigh and pwdata[15:14] == 2'b01 |=> monitorModeSel && !rtModeSel)
        else $error("monitor role not selected");
    chk_mem_area_wr: assert property (
        cfg1WriteHigh |=> memoryAreaSelect == $past(pwdata[`TCW_B_MEM_AREA]))
        else $error("memory area not written");
    chk_msg_mon_wr: assert property (
        cfg1WriteHigh and enhancedMode |=> messageMonitorEnable == $past(pwdata[12]))
        else $error("message monitor enable not written");
    chk_alt_flag_map: assert property (
        altStatusMode |=> rtStatusFlags == altFlags($past(cfg1)))
        else $error("alternate status flags wrong");
    chk_mon_nonenh_idle: assert property (
        monitorModeSel && !enhancedMode && !wordMonitorActive |=> !wordMonitorActive)
        else $error("monitor started outside enhanced mode");
    chk_unmapped_err: assert property (
        psel && penable && !mapped |-> pslverr && pready)
        else $error("unmapped access not flagged");

endmodule

// >>> dv/tcw_host_model.sv
// Host processor model: APB master for the configuration block.
// Assumes one clock; the bench calls xfer to move one register word.
`timescale 1ns/100ps

module tcw_host_model (
    input wire logic clk_sys,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
    end

    // ----------------------------------------
    // One transfer, held until pready
    // ----------------------------------------
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// >>> dv/tcw_config_one_tb.sv
// Self-checking bench for configuration word one, compared with a bench model.
// Assumes registers reached over APB through the host model.
`timescale 1ns/100ps
`include "tcw_consts.svh"

module tcw_config_one_tb;
    localparam logic [11:0] A1 = {`TCW_IDX_CFG1, 2'b00};
    localparam logic [11:0] A3 = {`TCW_IDX_CFG3, 2'b00};
    localparam logic [11:0] AS = {`TCW_IDX_STAT, 2'b00};
    localparam logic [11:0] AT = {`TCW_IDX_TRIG, 2'b00};
    localparam logic [11:0] AU = 12'h020;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic msgBusy, wordValid, extPin;
    logic [15:0] rxWord;
    logic rtModeSel, monitorModeSel, enhancedMode, altStatusMode;
    logic memoryAreaSelect, messageMonitorEnable, wordMonitorActive, monitorTriggered;
    logic [10:0] rtStatusFlags;
    logic [15:0] mC1 = 16'h8000;
    logic [15:0] mC3 = 16'h0000;
    logic [15:0] mWord = 16'h0000;
    logic [15:0] seed = 16'h0051;
    logic mBusy = 1'b0;
    logic mAct = 1'b0;
    logic mTrg = 1'b0;
    int errors = 0;
    int numChecks = 0;

    always #2 clk_sys = ~clk_sys;

    tcw_host_model i_host (.clk_sys(clk_sys), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

    tcw_config_one i_dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .msgBusy(msgBusy), .wordValid(wordValid),
        .rxWord(rxWord), .externalStartPin(extPin), .rtModeSel(rtModeSel),
        .monitorModeSel(monitorModeSel), .enhancedMode(enhancedMode),
        .altStatusMode(altStatusMode), .memoryAreaSelect(memoryAreaSelect),
        .messageMonitorEnable(messageMonitorEnable), .rtStatusFlags(rtStatusFlags),
        .wordMonitorActive(wordMonitorActive), .monitorTriggered(monitorTriggered));

    // ----------------------------------------
    // Bench model and helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [15:0] wmask();
        case (mC1[15:14])
            2'b10: wmask = (mC3[15] & mC3[5]) ? `TCW_WMASK_RT_ALT : `TCW_WMASK_RT;
            2'b01: wmask = `TCW_WMASK_MON;
            default: wmask = `TCW_WMASK_OTHER;
        endcase
    endfunction

    function automatic logic [15:0] exp1();
        exp1 = mC1 & wmask();
        if (mC1[15:14] == 2'b10) exp1[0] = mBusy & mC3[15];
        if (mC1[15:14] == 2'b01 && mC3[15]) exp1[2:0] = {1'b1, mTrg, mAct};
    endfunction

    function automatic logic [10:0] expFlags();
        expFlags = 11'h000;
        if (mC1[15:14] == 2'b10 && mC3[15] && mC3[5]) begin
            for (int k = 0; k < 11; k++) expFlags[k] = mC1[11-k];
        end else if (mC1[15:14] == 2'b10) begin
            expFlags[10] = mC3[15] & !mC1[7];
        end
    endfunction

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wrReg(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
        logic [15:0] bm;
        logic [31:0] r;
        logic e;
        bm = {{8{s[1]}}, {8{s[0]}}};
        i_host.xfer(1'b1, a, {16'h0000, d}, s, r, e);
        if (a == A1) mC1 = (mC1 & ~(bm & wmask())) | (d & bm & wmask());
        if (a == A3) mC3 = (mC3 & ~(bm & `TCW_WMASK_CFG3)) | (d & bm & `TCW_WMASK_CFG3);
        if (a == AT) mWord = (mWord & ~bm) | (d & bm);
    endtask

    task automatic rdChk(input logic [11:0] a, input string n);
        logic [31:0] r;
        logic e;
        logic [15:0] x;
        i_host.xfer(1'b0, a, 32'h00000000, 4'h0, r, e);
        x = (a == A1) ? exp1() : (a == A3) ? mC3 : (a == AT) ? mWord :
            (a == AS) ? {2'b00, mTrg, mAct, mBusy, expFlags()} : 16'h0000;
        chk(n, r, {16'h0000, x});
        chk("pslverr", e, a == AU);
    endtask

    task automatic chkOuts();
        logic rt;
        tick(3);
        rt = mC1[15:14] == 2'b10;
        chk("rtModeSel", rtModeSel, rt);
        chk("monitorModeSel", monitorModeSel, mC1[15:14] == 2'b01);
        chk("enhancedMode", enhancedMode, mC3[15]);
        chk("altStatusMode", altStatusMode, rt & mC3[15] & mC3[5]);
        chk("memoryAreaSelect", memoryAreaSelect, mC1[13]);
        chk("msgMonEnable", messageMonitorEnable,
            mC1[12] & !(mC1[15:14] == 2'b01 && !mC3[15]));
        chk("monitorActive", wordMonitorActive, mAct);
        chk("monitorTriggered", monitorTriggered, mTrg);
        chk("rtStatusFlags", rtStatusFlags, expFlags());
    endtask

    task automatic sendWord(input logic [15:0] w);
        @(posedge clk_sys);
        wordValid <= 1'b1;
        rxWord <= w;
        @(posedge clk_sys);
        wordValid <= 1'b0;
    endtask

    task automatic wrap_up();
        if (errors == 0 && numChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        msgBusy = 1'b0;
        wordValid = 1'b0;
        rxWord = 16'h0000;
        extPin = 1'b0;
        tick(4);
        rstn <= 1'b1;
        rdChk(A1, "cfg1");
        chkOuts();
        wrReg(AU, 16'hFFFF, 4'hF);
        rdChk(AU, "unmapped");
        wrReg(AS, 16'hFFFF, 4'hF);
        wrReg(A3, 16'h8000, 4'hF);
        wrReg(A1, 16'hBFFF, 4'hF);
        rdChk(A1, "cfg1");
        chkOuts();
        wrReg(A1, 16'h807F, 4'h1);
        chkOuts();
        msgBusy <= 1'b1;
        mBusy = 1'b1;
        tick(3);
        rdChk(A1, "cfg1");
        rdChk(AS, "status");
        msgBusy <= 1'b0;
        mBusy = 1'b0;
        tick(3);
        rdChk(A1, "cfg1");
        wrReg(A3, 16'h8020, 4'hF);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            msgBusy <= seed[15];
            mBusy = seed[15];
            wrReg(A1, {2'b10, seed[13:0]}, 4'hF);
            rdChk(A1, "cfg1");
            rdChk(AS, "status");
            chkOuts();
        end
        msgBusy <= 1'b0;
        mBusy = 1'b0;
        wrReg(A3, 16'h0020, 4'hF);
        chkOuts();
        wrReg(A3, 16'h8000, 4'hF);
        wrReg(A1, 16'h4000, 4'hF);
        seed = lfsr(seed);
        wrReg(AT, seed, 4'hF);
        rdChk(AT, "trigWord");
        wrReg(A1, 16'h4C00, 4'hF);
        sendWord(~mWord);
        chkOuts();
        sendWord(mWord);
        mAct = 1'b1;
        mTrg = 1'b1;
        chkOuts();
        rdChk(A1, "cfg1");
        rdChk(AS, "status");
        wrReg(A1, 16'h4E00, 4'hF);
        sendWord(mWord);
        mAct = 1'b0;
        chkOuts();
        wrReg(A1, 16'h4880, 4'hF);
        @(posedge clk_sys);
        extPin <= 1'b1;
        tick(3);
        extPin <= 1'b0;
        mAct = 1'b1;
        chkOuts();
        wrReg(A1, 16'h4A80, 4'hF);
        sendWord(mWord);
        mAct = 1'b0;
        wrReg(A1, 16'h4480, 4'hF);
        mTrg = 1'b0;
        sendWord(mWord);
        chkOuts();
        wrReg(A3, 16'h0000, 4'hF);
        wrReg(A1, 16'h5C00, 4'hF);
        sendWord(mWord);
        chkOuts();
        rdChk(A1, "cfg1");
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        wrap_up();
    end
endmodule
